/* hdl/sad_stage_cfg.sv */
`timescale 1ns/100ps
`default_nettype none

module sad_stage_cfg (
    input wire logic clk,                        // 200 MHz device clock
    input wire logic resetn,                     // asynchronous reset, active low
    input wire logic reg_wr,                     // register write strobe
    input wire logic reg_rd,                     // register read strobe
    input wire logic [9:0] reg_addr,             // register word address
    input wire logic [15:0] reg_wdata,           // write data
    output logic [15:0] reg_rdata,               // read data, held until next read
    output logic reg_rvalid,                     // read data valid pulse
    output logic reg_err,                        // pulse: access to unmapped address
    input wire logic [2:0] stage_sel,            // stage now being converted
    output logic [7:0] in_to_neg,                // input n on converter negative side
    output logic [7:0] in_to_pos,                // input n on converter positive side
    output logic [7:0] in_to_bias,               // input n tied to bias node
    output logic [1:0] measure_mode,             // measurement mode code
    output logic mode_reserved,                  // mode code zero programmed
    output logic [5:0] neg_offset_magnitude,     // zero when suppressed
    output logic neg_offset_to_pos,              // negative offset lands on positive side
    output logic [5:0] pos_offset_magnitude,     // zero when suppressed
    output logic pos_offset_to_neg,              // positive offset lands on negative side
    output logic [13:0] neg_trip_percent,        // hundredths of a percent
    output logic [13:0] pos_trip_percent,        // hundredths of a percent
    output logic [6:0] neg_peak_level,           // percent
    output logic [6:0] pos_peak_level,           // percent
    output logic peak_code_bad                   // undefined peak code on either side
);

    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------
    // sixteen-entry trip table, hundredths of a percent
    function automatic logic [13:0] trip_pct(input logic [3:0] code);
        logic [13:0] pct;
        pct = 14'h0000;
        unique case (code)
            4'h0: pct = 14'd2500;
            4'h1: pct = 14'd2973;
            4'h2: pct = 14'd3440;
            4'h3: pct = 14'd3908;
            4'h4: pct = 14'd4379;
            4'h5: pct = 14'd4848;
            4'h6: pct = 14'd5315;
            4'h7: pct = 14'd5783;
            4'h8: pct = 14'd6251;
            4'h9: pct = 14'd6722;
            4'ha: pct = 14'd7190;
            4'hb: pct = 14'd7658;
            4'hc: pct = 14'd8128;
            4'hd: pct = 14'd8596;
            4'he: pct = 14'd9064;
            4'hf: pct = 14'd9532;
        endcase
        return pct;
    endfunction

    // ten-percent ladder from forty; undefined codes saturate at the top
    function automatic logic [6:0] peak_pct(input logic [2:0] code);
        logic [2:0] c;
        c = (code > sad_pkg::PEAK_LAST_CODE) ? sad_pkg::PEAK_LAST_CODE : code;
        return 7'(sad_pkg::PEAK_BASE_PCT + 7'(c) * sad_pkg::PEAK_STEP_PCT);
    endfunction

    // two-bit route code to one-hot side flags
    function automatic logic [2:0] route_dec(input logic [1:0] code);
        logic [2:0] r;
        r = 3'h0;
        unique case (sad_route_cast(code))
            sad_pkg::SAD_ROUTE_OPEN: r = 3'b000;
            sad_pkg::SAD_ROUTE_NEG:  r = 3'b001;
            sad_pkg::SAD_ROUTE_POS:  r = 3'b010;
            sad_pkg::SAD_ROUTE_BIAS: r = 3'b100;
        endcase
        return r;
    endfunction

    function automatic sad_pkg::sad_route_e sad_route_cast(input logic [1:0] code);
        return sad_pkg::sad_route_e'(code);
    endfunction

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    logic addr_hit;
    logic [2:0] addr_stage;
    logic [1:0] addr_word;

    // only the first four words of each eight-word stage block live here
    assign addr_hit = (reg_addr >= sad_pkg::BANK_BASE) && (reg_addr <= sad_pkg::BANK_LAST)
                      && (reg_addr[2:0] <= sad_pkg::OFS_LAST_WORD);
    assign addr_stage = reg_addr[5:3];
    assign addr_word = reg_addr[1:0];

    // ------------------------------------------------------------
    // stage configuration storage
    // ------------------------------------------------------------
    logic [15:0] cfg_q [sad_pkg::NUM_STAGES][4];

    // each stage has its own four words; reserved bits are kept as written
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int s = 0; s < sad_pkg::NUM_STAGES; s++) begin
                for (int w = 0; w < 4; w++) begin
                    cfg_q[s][w] <= sad_pkg::WORD_RESET;
                end
            end
        end else if (reg_wr && addr_hit) begin
            cfg_q[addr_stage][addr_word] <= reg_wdata;
        end
    end

    // read port: data one cycle after the strobe, unmapped reads give zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 16'h0000;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= addr_hit ? cfg_q[addr_stage][addr_word] : 16'h0000;
            end
        end
    end

    // flags accesses that miss the bank so a bad host address shows up
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_err <= 1'b0;
        end else begin
            reg_err <= (reg_wr || reg_rd) && !addr_hit;
        end
    end

    // ------------------------------------------------------------
    // front end decode of the active stage
    // ------------------------------------------------------------
    logic [15:0] w_low, w_conn, w_off, w_sens;
    logic [2:0] rt [8];

    assign w_low = cfg_q[stage_sel][sad_pkg::OFS_CONN_LOW[1:0]];
    assign w_conn = cfg_q[stage_sel][sad_pkg::OFS_INPUT8_CONN[1:0]];
    assign w_off = cfg_q[stage_sel][sad_pkg::OFS_OFFSET_CTRL[1:0]];
    assign w_sens = cfg_q[stage_sel][sad_pkg::OFS_SENS_CTRL[1:0]];

    // inputs one to seven from the companion word, input eight from its own
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            rt[i] = route_dec(w_low[2*i +: 2]);
        end
        rt[7] = route_dec(w_conn[sad_pkg::ROUTE_LSB +: 2]);
    end

    // switch matrix flags, registered so the analog side sees clean levels
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            in_to_neg <= 8'h00;
            in_to_pos <= 8'h00;
            in_to_bias <= 8'h00;
        end else begin
            for (int i = 0; i < 8; i++) begin
                in_to_neg[i] <= rt[i][0];
                in_to_pos[i] <= rt[i][1];
                in_to_bias[i] <= rt[i][2];
            end
        end
    end

    // mode code passed through; code zero flagged, converter must not trust it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            measure_mode <= 2'b00;
            mode_reserved <= 1'b0;
        end else begin
            measure_mode <= w_conn[sad_pkg::MODE_LSB +: 2];
            mode_reserved <= (w_conn[sad_pkg::MODE_LSB +: 2] == sad_pkg::SAD_MODE_RSVD);
        end
    end

    // offsets: a suppressed side drives zero magnitude, steer picks the input
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            neg_offset_magnitude <= 6'h00;
            pos_offset_magnitude <= 6'h00;
            neg_offset_to_pos <= 1'b0;
            pos_offset_to_neg <= 1'b0;
        end else begin
            neg_offset_magnitude <= w_conn[sad_pkg::NEG_OFF_BIT] ? 6'h00
                                    : w_off[sad_pkg::NEG_MAG_LSB +: 6];
            pos_offset_magnitude <= w_conn[sad_pkg::POS_OFF_BIT] ? 6'h00
                                    : w_off[sad_pkg::POS_MAG_LSB +: 6];
            neg_offset_to_pos <= w_off[sad_pkg::NEG_STEER_BIT];
            pos_offset_to_neg <= w_off[sad_pkg::POS_STEER_BIT];
        end
    end

    // sensitivity tables; one function serves both polarities
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            neg_trip_percent <= 14'h0000;
            pos_trip_percent <= 14'h0000;
            neg_peak_level <= 7'h00;
            pos_peak_level <= 7'h00;
            peak_code_bad <= 1'b0;
        end else begin
            neg_trip_percent <= trip_pct(w_sens[sad_pkg::NEG_TRIP_LSB +: 4]);
            pos_trip_percent <= trip_pct(w_sens[sad_pkg::POS_TRIP_LSB +: 4]);
            neg_peak_level <= peak_pct(w_sens[sad_pkg::NEG_PEAK_LSB +: 3]);
            pos_peak_level <= peak_pct(w_sens[sad_pkg::POS_PEAK_LSB +: 3]);
            // undefined codes are a host fault; saturate and report
            peak_code_bad <= (w_sens[sad_pkg::NEG_PEAK_LSB +: 3] > sad_pkg::PEAK_LAST_CODE)
                          || (w_sens[sad_pkg::POS_PEAK_LSB +: 3] > sad_pkg::PEAK_LAST_CODE);
        end
    end

endmodule

`default_nettype wire

/* hdl/sad_pkg.sv */
`default_nettype none

package sad_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int NUM_STAGES = 8;
    localparam logic [9:0] BANK_BASE = 10'h080;        // stage 0 first word
    localparam logic [9:0] BANK_LAST = 10'h0bf;        // stage 7 last word
    localparam logic [2:0] OFS_CONN_LOW = 3'h0;        // inputs one to seven
    localparam logic [2:0] OFS_INPUT8_CONN = 3'h1;     // stage_input8_connection
    localparam logic [2:0] OFS_OFFSET_CTRL = 3'h2;     // stage_offset_control
    localparam logic [2:0] OFS_SENS_CTRL = 3'h3;       // stage_sensitivity_control
    localparam logic [2:0] OFS_LAST_WORD = 3'h3;
    localparam logic [15:0] WORD_RESET = 16'h0000;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int ROUTE_LSB = 0;          // input8_route_select [1:0]
    localparam int MODE_LSB = 12;          // measure_mode_select [13:12]
    localparam int NEG_OFF_BIT = 14;       // neg_offset_off
    localparam int POS_OFF_BIT = 15;       // pos_offset_off
    localparam int NEG_MAG_LSB = 0;        // neg_offset_magnitude [5:0]
    localparam int NEG_STEER_BIT = 7;      // neg_offset_steer
    localparam int POS_MAG_LSB = 8;        // pos_offset_magnitude [13:8]
    localparam int POS_STEER_BIT = 15;     // pos_offset_steer
    localparam int NEG_TRIP_LSB = 0;       // neg_trip_percent [3:0]
    localparam int NEG_PEAK_LSB = 4;       // neg_peak_level [6:4]
    localparam int POS_TRIP_LSB = 8;       // positive trip percent [11:8]
    localparam int POS_PEAK_LSB = 12;      // positive peak level [14:12]

    // capacitance step of one magnitude count, in femtofarads
    localparam int OFFSET_STEP_FF = 320;

    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SAD_ROUTE_OPEN = 2'b00,
        SAD_ROUTE_NEG  = 2'b01,
        SAD_ROUTE_POS  = 2'b10,
        SAD_ROUTE_BIAS = 2'b11
    } sad_route_e;

    typedef enum logic [1:0] {
        SAD_MODE_RSVD   = 2'b00,
        SAD_MODE_SE_POS = 2'b01,
        SAD_MODE_SE_NEG = 2'b10,
        SAD_MODE_DIFF   = 2'b11
    } sad_mode_e;

    // peak level: base percent and step per code, last legal code
    localparam logic [6:0] PEAK_BASE_PCT = 7'h28;      // 40 percent
    localparam logic [6:0] PEAK_STEP_PCT = 7'h0a;      // 10 percent
    localparam logic [2:0] PEAK_LAST_CODE = 3'h5;

endpackage

`default_nettype wire

/* dv/sad_cfg_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module sad_cfg_checker (
    input wire logic clk, // device clock
    input wire logic resetn, // reset, active low
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    input wire logic [9:0] reg_addr, // word address
    input wire logic [15:0] reg_rdata, // read data
    input wire logic reg_rvalid, // read valid
    input wire logic reg_err, // unmapped flag
    input wire logic [7:0] in_to_neg, // negative side
    input wire logic [7:0] in_to_pos, // positive side
    input wire logic [7:0] in_to_bias, // bias node
    input wire logic [1:0] measure_mode, // mode code
    input wire logic mode_reserved, // mode zero flag
    input wire logic [13:0] neg_trip_percent, // hundredths
    input wire logic [6:0] pos_peak_level // percent
);
    // ------------------------------------------------------------
    // port and decode properties
    // ------------------------------------------------------------
    // words four to seven of a stage belong to other logic
    logic hit_bad;
    assign hit_bad = (reg_rd || reg_wr) && (reg_addr < sad_pkg::BANK_BASE ||
        reg_addr > sad_pkg::BANK_LAST || reg_addr[2]);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    chk_read_answer: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered");
    chk_valid_cause: assert property (reg_rvalid |-> $past(reg_rd))
        else $error("read valid without read");
    chk_err_unmapped: assert property (hit_bad |=> reg_err)
        else $error("unmapped access not flagged");
    chk_err_cause: assert property (reg_err |-> $past(hit_bad))
        else $error("error flag without cause");
    chk_unmapped_zero: assert property (hit_bad && reg_rd |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    chk_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
        else $error("read data moved without read");
    // one input never lands on two nodes; skip the edge leaving reset
    chk_route_single: assert property ($past(resetn) |-> ((in_to_neg & in_to_pos)
        | (in_to_neg & in_to_bias) | (in_to_pos & in_to_bias)) == 8'h00)
        else $error("input routed twice");
    chk_mode_flag: assert property ($past(resetn) |-> mode_reserved == (measure_mode == 2'b00))
        else $error("mode flag disagrees");
    chk_trip_span: assert property ($past(resetn) |-> neg_trip_percent >= 14'h09c4
        && neg_trip_percent <= 14'h253c) else $error("trip percent out of table");
    chk_peak_step: assert property ($past(resetn) |-> pos_peak_level >= 7'h28
        && pos_peak_level <= 7'h5a && pos_peak_level % 10 == 0) else $error("peak level off step");
    cov_read: cover property (reg_rd ##1 reg_rvalid);
    cov_unmapped: cover property (hit_bad ##1 reg_err);
    cov_back_to_back: cover property (reg_wr ##2 reg_wr);
endmodule
bind sad_stage_cfg sad_cfg_checker u_sad_cfg_checker (.clk, .resetn, .reg_wr, .reg_rd,
    .reg_addr, .reg_rdata, .reg_rvalid, .reg_err, .in_to_neg, .in_to_pos, .in_to_bias,
    .measure_mode, .mode_reserved, .neg_trip_percent, .pos_peak_level);
`default_nettype wire

/* dv/sad_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module sad_host_model (
    input wire logic clk, // device clock
    output logic reg_wr = 1'b0, // write strobe
    output logic reg_rd = 1'b0, // read strobe
    output logic [9:0] reg_addr = 10'h000, // word address
    output logic [15:0] reg_wdata = 16'h0000, // write data
    input wire logic [15:0] reg_rdata, // read data
    input wire logic reg_rvalid // read valid
);
    // ------------------------------------------------------------
    // host side of the register port
    // ------------------------------------------------------------
    // a careful host: reserved bits zero, mode zero and peak six, seven never sent
    function automatic logic [15:0] legal(input logic [1:0] w, input logic [15:0] d);
        logic [15:0] r;
        r = d;
        case (w)
            2'h0: r[15:14] = 2'h0;
            2'h1: begin
                r[11:2] = 10'h000;
                if (r[13:12] == 2'b00) r[13:12] = 2'b11;
            end
            2'h2: r = r & 16'hbfbf;
            default: begin
                r = r & 16'h7f7f;
                if (r[6:4] > 3'h5) r[6:4] = 3'h5;
                if (r[14:12] > 3'h5) r[14:12] = 3'h5;
            end
        endcase
        return r;
    endfunction
    // data inverted once released so a stale value cannot pass
    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [9:0] a, output logic [15:0] d, output logic v);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
        v = reg_rvalid;
    endtask
endmodule
`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    // ------------------------------------------------------------
    // clock, design, host
    // ------------------------------------------------------------
    localparam logic [13:0] TRIP [16] = '{14'h09c4, 14'h0b9d, 14'h0d70, 14'h0f44, 14'h111b,
        14'h12f0, 14'h14c3, 14'h1697, 14'h186b, 14'h1a42, 14'h1c16, 14'h1dea, 14'h1fc0,
        14'h2194, 14'h2368, 14'h253c};
    localparam logic [9:0] BAD [4] = '{10'h07f, 10'h084, 10'h0bc, 10'h0c0};
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [2:0] stage_sel = 3'h0;
    logic reg_wr, reg_rd, reg_rvalid, reg_err, mode_reserved, peak_code_bad;
    logic neg_offset_to_pos, pos_offset_to_neg;
    logic [9:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    logic [7:0] in_to_neg, in_to_pos, in_to_bias;
    logic [1:0] measure_mode;
    logic [5:0] neg_offset_magnitude, pos_offset_magnitude;
    logic [13:0] neg_trip_percent, pos_trip_percent;
    logic [6:0] neg_peak_level, pos_peak_level;
    logic [15:0] mirror [32];
    int bad_count = 0;
    int checks_done = 0;
    int cycles = 0;
    always #2.5 clk = ~clk;
    sad_stage_cfg u_sad_stage_cfg (.clk, .resetn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata, .reg_rvalid, .reg_err, .stage_sel, .in_to_neg, .in_to_pos, .in_to_bias,
        .measure_mode, .mode_reserved, .neg_offset_magnitude, .neg_offset_to_pos,
        .pos_offset_magnitude, .pos_offset_to_neg, .neg_trip_percent, .pos_trip_percent,
        .neg_peak_level, .pos_peak_level, .peak_code_bad);
    sad_host_model u_sad_host_model (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata, .reg_rvalid);
    task automatic summarize();
        if (bad_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    // decode of one stage worked out from the words last sent
    task automatic check_stage(input int s);
        logic [15:0] cn, c8, of, se;
        logic [1:0] f;
        logic [7:0] en, ep, eb;
        cn = mirror[s*4];
        c8 = mirror[s*4+1];
        of = mirror[s*4+2];
        se = mirror[s*4+3];
        for (int i = 0; i < 8; i++) begin
            f = (i == 7) ? c8[1:0] : cn[2*i+:2];
            en[i] = (f == 2'b01);
            ep[i] = (f == 2'b10);
            eb[i] = (f == 2'b11);
        end
        stage_sel <= 3'(s);
        repeat (2) @(posedge clk);
        cmp("in_to_neg", 16'(en), 16'(in_to_neg));
        cmp("in_to_pos", 16'(ep), 16'(in_to_pos));
        cmp("in_to_bias", 16'(eb), 16'(in_to_bias));
        cmp("measure_mode", 16'(c8[13:12]), 16'(measure_mode));
        cmp("mode_reserved", 16'(c8[13:12] == 2'b00), 16'(mode_reserved));
        cmp("neg_mag", 16'(c8[14] ? 6'h00 : of[5:0]), 16'(neg_offset_magnitude));
        cmp("pos_mag", 16'(c8[15] ? 6'h00 : of[13:8]), 16'(pos_offset_magnitude));
        cmp("steer", {14'h0, of[7], of[15]}, {14'h0, neg_offset_to_pos, pos_offset_to_neg});
        cmp("neg_trip", 16'(TRIP[se[3:0]]), 16'(neg_trip_percent));
        cmp("pos_trip", 16'(TRIP[se[11:8]]), 16'(pos_trip_percent));
        // codes past the last legal one saturate at ninety and raise the flag
        cmp("neg_peak", 16'((se[6:4] > 3'h5) ? 7'h5a : 7'h28 + 7'h0a * se[6:4]),
            16'(neg_peak_level));
        cmp("pos_peak", 16'((se[14:12] > 3'h5) ? 7'h5a : 7'h28 + 7'h0a * se[14:12]),
            16'(pos_peak_level));
        cmp("peak_code_bad", 16'((se[6:4] > 3'h5) || (se[14:12] > 3'h5)),
            16'(peak_code_bad));
    endtask
    // hang guard, far above the six hundred or so cycles the run needs
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            summarize();
        end
    end
    // reset state, then one all-ones round and two random rounds
    initial begin
        logic [15:0] d;
        logic v;
        d = 16'($urandom(32'h7a44023d));
        for (int i = 0; i < 32; i++) mirror[i] = 16'h0000;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        for (int s = 0; s < 8; s++) check_stage(s);
        for (int r = 0; r < 3; r++) begin
            for (int i = 0; i < 32; i++) begin
                d = (r == 0) ? 16'hffff : 16'($urandom);
                mirror[i] = u_sad_host_model.legal(2'(i), d);
                u_sad_host_model.wr(sad_pkg::BANK_BASE + 10'(i / 4 * 8 + i % 4), mirror[i]);
            end
            for (int i = 0; i < 32; i++) begin
                u_sad_host_model.rd(sad_pkg::BANK_BASE + 10'(i / 4 * 8 + i % 4), d, v);
                cmp("readback", mirror[i], d);
                cmp("rvalid", 16'h0001, 16'(v));
                cmp("reg_err", 16'h0000, 16'(reg_err));
            end
            for (int s = 0; s < 8; s++) check_stage(s);
        end
        // undefined peak codes sent on purpose: a careless host must not upset the ladder
        mirror[3] = 16'h6070;
        u_sad_host_model.wr(sad_pkg::BANK_BASE + 10'h003, mirror[3]);
        check_stage(0);
        // unmapped places below, between and above the stage words
        foreach (BAD[k]) begin
            u_sad_host_model.wr(BAD[k], 16'h5a5a);
            u_sad_host_model.rd(BAD[k], d, v);
            cmp("unmapped_read", 16'h0000, d);
            cmp("reg_err", 16'h0001, 16'(reg_err));
        end
        u_sad_host_model.rd(sad_pkg::BANK_BASE, d, v);
        cmp("word_kept", mirror[0], d);
        summarize();
    end
endmodule
`default_nettype wire
